// *** rtl/ducr2_pkg.sv ***
/*
 * package for the second control register of the upconverter:
 * addresses, bit positions, masks, reset value and mode codes.
 * assumes an 8-bit register address from the serial port decoder.
 */
package ducr2_pkg;

   // ==========================================================
   // addresses
   localparam logic [7:0]  CR2_ADDR      = 8'h01;
   localparam logic [7:0]  TUNING_ADDR   = 8'h07;

   // ==========================================================
   // bit positions
   localparam int          BIT_SER_MODE  = 31;
   localparam int          BIT_SER_LSB   = 30;
   localparam int          BIT_EARLY_FS  = 29;
   localparam int          BIT_AMP_SRC   = 24;
   localparam int          BIT_INT_UPD   = 23;
   localparam int          BIT_SYNC_EN   = 22;
   localparam int          BIT_RD_EFF    = 16;
   localparam int          RATE_HI       = 15;
   localparam int          RATE_LO       = 14;

   // ==========================================================
   // masks and reset value
   localparam logic [31:0] CR2_WR_MASK   = 32'hE1C1_C000;
   localparam logic [31:0] CR2_RESET     = 32'h0040_0000;
   localparam logic [17:0] GPIO_PIN_MASK = 18'h3_FFCF;
   localparam logic [17:0] SER_PIN_MASK  = 18'h0_0030;
   localparam logic [17:0] PAR_PIN_MASK  = 18'h3_FFFF;

   // ==========================================================
   // counts
   localparam logic [1:0]  SYNC_DIV_LAST = 2'h3;
   localparam logic [2:0]  PRE_ZERO      = 3'h0;
   localparam logic [15:0] PERIOD_ZERO   = 16'h0000;

   // ==========================================================
   // operating mode of the first control register
   typedef enum logic [1:0] {
      DUCR2_MODE_QUAD   = 2'b00,
      DUCR2_MODE_TONE   = 2'b01,
      DUCR2_MODE_IDAC   = 2'b10,
      DUCR2_MODE_RSVD   = 2'b11
   } ducr2_mode_e;

   // update prescaler ratio
   typedef enum logic [1:0] {
      DUCR2_PRE_DIV1    = 2'b00,
      DUCR2_PRE_DIV2    = 2'b01,
      DUCR2_PRE_DIV4    = 2'b10,
      DUCR2_PRE_DIV8    = 2'b11
   } ducr2_pre_e;

endpackage

// *** rtl/ducr2_upd_timer.sv ***
/*
 * internal update timer: prescaler by 1, 2, 4 or 8, then a period
 * counter; gives a one-cycle tick at the end of each period.
 * assumes period is steady while enabled; zero period means one
 * prescaled tick per update.
 */
`timescale 1ns/1ns
module ducr2_upd_timer (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // control
   input  wire logic        enable,
   input  wire logic [1:0]  prescale,
   input  wire logic [15:0] period,
   // event
   output logic             tick_q
);

   // ==========================================================
   // prescaler and period counter
   logic [2:0]  pre_cnt_q;
   logic [2:0]  pre_cnt_d;
   logic [2:0]  pre_last;
   logic [15:0] per_cnt_q;
   logic [15:0] per_cnt_d;
   logic        tick_d;
   logic        pre_tick;

   always_comb begin
      case (ducr2_pkg::ducr2_pre_e'(prescale))
         ducr2_pkg::DUCR2_PRE_DIV1: pre_last = 3'h0;
         ducr2_pkg::DUCR2_PRE_DIV2: pre_last = 3'h1;
         ducr2_pkg::DUCR2_PRE_DIV4: pre_last = 3'h3;
         ducr2_pkg::DUCR2_PRE_DIV8: pre_last = 3'h7;
         default:                   pre_last = 3'h0;
      endcase
      pre_tick  = enable && (pre_cnt_q >= pre_last);
      pre_cnt_d = pre_tick ? ducr2_pkg::PRE_ZERO : pre_cnt_q + 3'h1;
      per_cnt_d = per_cnt_q;
      tick_d    = 1'b0;
      if (!enable) begin
         pre_cnt_d = ducr2_pkg::PRE_ZERO;
         per_cnt_d = ducr2_pkg::PERIOD_ZERO;
      end else if (pre_tick) begin
         if (per_cnt_q >= period) begin
            per_cnt_d = ducr2_pkg::PERIOD_ZERO;
            tick_d    = 1'b1;
         end else begin
            per_cnt_d = per_cnt_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pre_cnt_q <= ducr2_pkg::PRE_ZERO;
         per_cnt_q <= ducr2_pkg::PERIOD_ZERO;
         tick_q    <= 1'b0;
      end else begin
         pre_cnt_q <= pre_cnt_d;
         per_cnt_q <= per_cnt_d;
         tick_q    <= tick_d;
      end
   end

endmodule

// *** rtl/ducr2_ctrl_reg.sv ***
/*
 * second control register of the quadrature upconverter: buffered
 * and active copies, update-pin control, sync clock, port mode
 * decode and tuning-word read selection.
 * assumes the serial port decoder gives one-cycle read and write
 * strobes with an address, and that the mode and keying inputs come
 * from the active first control register.
 * the update pin belongs to the host unless bit 23 is set.
 */
//
// Overview of operation
// - register lives at serial address 0x01, four bytes wide.
// - data-port mode bit 31 acts only in quadrature mode 00b.
// - bit 31 clear: all eighteen data pins form one parallel port.
// - bit 31 set: pins 5,4 serial data; others a 16-bit GPIO port.
// - bit 30 picks serial bit order, 0 MSB first, 1 LSB first.
// - bit 29 picks frame sync, 0 late, 1 early.
// - amplitude-source bit 24 acts only in single tone with keying off.
// - bit 24 clear bypasses scaling at unity; set uses active profile.
// - internal-update bit 23 takes effect at once on write.
// - bit 23 clear: update pin is an input driven by the host.
// - bit 23 set: update strobe made inside and driven out on pin.
// - bit 22 set gives a quarter-rate sync clock output.
// - bit 22 clear holds the sync clock pin low.
// - bit 16 clear: tuning-word read returns the stored word.
// - bit 16 set: tuning-word read returns the accumulator input word.
// - update-rate bits 15:14 used only while bit 23 is set.
// - rate 00 divides by 1, 01 by 2, 10 by 4.
`timescale 1ns/1ns
module ducr2_ctrl_reg (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // register access from the serial port decoder
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata_q,
   output logic             reg_rvalid_q,
   output logic             reg_hit_q,
   // tuning word sources
   input  wire logic [31:0] tuning_stored,
   input  wire logic [31:0] tuning_effective,
   // state of the first control register
   input  wire logic [1:0]  op_mode,
   input  wire logic        output_shift_keying_en,
   // update timer period
   input  wire logic [15:0] update_period,
   // update pin
   input  wire logic        io_update_in,
   output logic             io_update_out_q,
   output logic             io_update_oe_q,
   output logic             update_event_q,
   // sync clock pin
   output logic             sync_clk_q,
   // data port configuration
   output logic             dual_serial_data_port_q,
   output logic [17:0]      parallel_pin_mask_q,
   output logic [17:0]      serial_pin_mask_q,
   output logic [17:0]      gpio_pin_mask_q,
   output logic             serial_lsb_first_q,
   output logic             serial_early_fsync_q,
   // amplitude scale
   output logic             amp_from_profile_q,
   output logic             amp_bypass_q
);

   // ==========================================================
   // update pin sampling
   logic        pin_last_q;
   logic        pin_last_d;
   logic        pin_rise;

   always_comb begin
      // reset value matches the idle pin, so no false edge
      pin_last_d = io_update_in;
      pin_rise   = io_update_in && !pin_last_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pin_last_q <= 1'b0;
      end else begin
         pin_last_q <= pin_last_d;
      end
   end

   // ==========================================================
   // register copies
   logic [31:0] buf_q;
   logic [31:0] buf_d;
   logic [31:0] act_q;
   logic [31:0] act_d;
   logic        int_upd_q;
   logic        int_upd_d;
   logic        upd_now;
   logic        timer_tick;
   logic        wr_hit;

   always_comb begin
      wr_hit    = reg_wr && (reg_addr == ducr2_pkg::CR2_ADDR);
      buf_d     = buf_q;
      int_upd_d = int_upd_q;
      if (wr_hit) begin
         buf_d     = reg_wdata & ducr2_pkg::CR2_WR_MASK;
         int_upd_d = reg_wdata[ducr2_pkg::BIT_INT_UPD];
      end
      // host edge counts only while the pin is an input
      upd_now = int_upd_q ? timer_tick
                          : pin_rise;
      act_d = act_q;
      if (upd_now) begin
         act_d = buf_q;
      end
      // bit 23 skips the buffer so the pin turns at once
      act_d[ducr2_pkg::BIT_INT_UPD] = int_upd_d;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         buf_q     <= ducr2_pkg::CR2_RESET;
         act_q     <= ducr2_pkg::CR2_RESET;
         int_upd_q <= 1'b0;
      end else begin
         buf_q     <= buf_d;
         act_q     <= act_d;
         int_upd_q <= int_upd_d;
      end
   end

   // ==========================================================
   // internal update timer
   // ratio comes from the active copy, so a new rate waits for an update
   ducr2_upd_timer u_timer (
      .clk      (clk),
      .rst_b    (rst_b),
      .enable   (int_upd_q),
      .prescale (act_q[ducr2_pkg::RATE_HI:ducr2_pkg::RATE_LO]),
      .period   (update_period),
      .tick_q   (timer_tick)
   );

   // ==========================================================
   // update pin drive
   logic io_out_d;
   logic io_oe_d;
   logic evt_d;

   always_comb begin
      // pin driven only while the internal strobe owns it
      io_oe_d  = int_upd_q;
      io_out_d = int_upd_q && timer_tick;
      evt_d    = upd_now;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         io_update_out_q <= 1'b0;
         io_update_oe_q  <= 1'b0;
         update_event_q  <= 1'b0;
      end else begin
         io_update_out_q <= io_out_d;
         io_update_oe_q  <= io_oe_d;
         update_event_q  <= evt_d;
      end
   end

   // ==========================================================
   // sync clock, quarter of the system clock
   logic [1:0] sync_cnt_q;
   logic [1:0] sync_cnt_d;
   logic       sync_clk_d;

   always_comb begin
      // counter free-runs so the phase stays fixed across enables
      sync_cnt_d = sync_cnt_q + 2'h1;
      sync_clk_d = act_q[ducr2_pkg::BIT_SYNC_EN] && sync_cnt_d[1];
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sync_cnt_q <= 2'h0;
         sync_clk_q <= 1'b0;
      end else begin
         sync_cnt_q <= sync_cnt_d;
         sync_clk_q <= sync_clk_d;
      end
   end

   // ==========================================================
   // port mode decode
   logic        ser_d;
   logic        lsb_d;
   logic        efs_d;
   logic [17:0] par_mask_d;
   logic [17:0] ser_mask_d;
   logic [17:0] gpio_mask_d;

   always_comb begin
      // masks decoded here so the data path needs no mode logic
      ser_d = act_q[ducr2_pkg::BIT_SER_MODE] &&
              (op_mode == ducr2_pkg::DUCR2_MODE_QUAD);
      if (ser_d) begin
         par_mask_d  = 18'h0_0000;
         ser_mask_d  = ducr2_pkg::SER_PIN_MASK;
         gpio_mask_d = ducr2_pkg::GPIO_PIN_MASK;
      end else begin
         par_mask_d  = ducr2_pkg::PAR_PIN_MASK;
         ser_mask_d  = 18'h0_0000;
         gpio_mask_d = 18'h0_0000;
      end
      lsb_d = ser_d && act_q[ducr2_pkg::BIT_SER_LSB];
      efs_d = ser_d && act_q[ducr2_pkg::BIT_EARLY_FS];
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         dual_serial_data_port_q <= 1'b0;
         parallel_pin_mask_q     <= ducr2_pkg::PAR_PIN_MASK;
         serial_pin_mask_q       <= 18'h0_0000;
         gpio_pin_mask_q         <= 18'h0_0000;
         serial_lsb_first_q      <= 1'b0;
         serial_early_fsync_q    <= 1'b0;
      end else begin
         dual_serial_data_port_q <= ser_d;
         parallel_pin_mask_q     <= par_mask_d;
         serial_pin_mask_q       <= ser_mask_d;
         gpio_pin_mask_q         <= gpio_mask_d;
         serial_lsb_first_q      <= lsb_d;
         serial_early_fsync_q    <= efs_d;
      end
   end

   // ==========================================================
   // amplitude source decode
   logic        amp_prof_d;
   logic        amp_byp_d;
   logic        amp_valid;

   always_comb begin
      // outside single tone with keying off, scaling is left alone
      amp_valid  = (op_mode == ducr2_pkg::DUCR2_MODE_TONE) &&
                   !output_shift_keying_en;
      amp_prof_d = amp_valid && act_q[ducr2_pkg::BIT_AMP_SRC];
      amp_byp_d  = amp_valid && !act_q[ducr2_pkg::BIT_AMP_SRC];
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         amp_from_profile_q <= 1'b0;
         amp_bypass_q       <= 1'b0;
      end else begin
         amp_from_profile_q <= amp_prof_d;
         amp_bypass_q       <= amp_byp_d;
      end
   end

   // ==========================================================
   // read path
   logic [31:0] rdata_d;
   logic        rvalid_d;
   logic        hit_d;

   always_comb begin
      // answer stands one cycle, zero otherwise
      rdata_d  = 32'h0000_0000;
      hit_d    = 1'b0;
      rvalid_d = reg_rd;
      if (reg_rd) begin
         case (reg_addr)
            ducr2_pkg::CR2_ADDR: begin
               // programmed value, bit 23 as now in force
               rdata_d = buf_q & ducr2_pkg::CR2_WR_MASK;
               rdata_d[ducr2_pkg::BIT_INT_UPD] = int_upd_q;
               hit_d   = 1'b1;
            end
            ducr2_pkg::TUNING_ADDR: begin
               rdata_d = act_q[ducr2_pkg::BIT_RD_EFF] ? tuning_effective
                                                      : tuning_stored;
               hit_d   = 1'b1;
            end
            default: begin
               rdata_d = 32'h0000_0000;
               hit_d   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reg_rdata_q  <= 32'h0000_0000;
         reg_rvalid_q <= 1'b0;
         reg_hit_q    <= 1'b0;
      end else begin
         reg_rdata_q  <= rdata_d;
         reg_rvalid_q <= rvalid_d;
         reg_hit_q    <= hit_d;
      end
   end

endmodule

// *** verification/ducr2_ctrl_reg_sva.sv ***
/* checker for the second control register block, on its ports.
   assumes one clock, bound onto ducr2_ctrl_reg by the bind below. */
`timescale 1ns/1ns
module ducr2_ctrl_reg_sva (
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_b,
   // register access
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata_q,
   input wire logic        reg_rvalid_q,
   input wire logic        reg_hit_q,
   input wire logic [7:0]  reg_addr,
   // mode inputs
   input wire logic [1:0]  op_mode,
   input wire logic        output_shift_keying_en,
   // pins
   input wire logic        io_update_in,
   input wire logic        io_update_out_q,
   input wire logic        io_update_oe_q,
   input wire logic        update_event_q,
   input wire logic        sync_clk_q,
   // decoded configuration
   input wire logic        dual_serial_data_port_q,
   input wire logic [17:0] parallel_pin_mask_q,
   input wire logic [17:0] serial_pin_mask_q,
   input wire logic [17:0] gpio_pin_mask_q,
   input wire logic        serial_lsb_first_q,
   input wire logic        serial_early_fsync_q,
   input wire logic        amp_from_profile_q,
   input wire logic        amp_bypass_q
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // assertions
   a_read_answer: assert property (reg_rd |=> reg_rvalid_q) else $error("read not answered");
   a_open_zero: assert property (reg_rvalid_q && $past(reg_addr) == ducr2_pkg::CR2_ADDR |->
      (reg_rdata_q & 32'h1E3E_0000) == 32'h0000_0000) else $error("open bits not zero");
   a_dual_quad: assert property (dual_serial_data_port_q |-> $past(op_mode) == 2'b00)
      else $error("serial port outside quadrature");
   a_par_masks: assert property (!dual_serial_data_port_q |-> parallel_pin_mask_q == ducr2_pkg::PAR_PIN_MASK
      && serial_pin_mask_q == 18'h0_0000) else $error("parallel masks wrong");
   a_ser_masks: assert property (dual_serial_data_port_q |-> serial_pin_mask_q == ducr2_pkg::SER_PIN_MASK
      && gpio_pin_mask_q == ducr2_pkg::GPIO_PIN_MASK) else $error("serial masks wrong");
   a_ser_flags: assert property ((serial_lsb_first_q || serial_early_fsync_q) |-> dual_serial_data_port_q)
      else $error("serial flag without serial port");
   a_amp_gate: assert property ((amp_from_profile_q || amp_bypass_q) |-> $past(op_mode) == 2'b01
      && !$past(output_shift_keying_en) && !(amp_from_profile_q && amp_bypass_q))
      else $error("amplitude source misgated");
   a_int_pulse: assert property (io_update_out_q |-> io_update_oe_q && update_event_q)
      else $error("internal update pulse wrong");
   a_pin_update: assert property (io_update_in && !$past(io_update_in) && !io_update_oe_q |->
      ##[1:2] update_event_q) else $error("pin edge gave no update");
   a_sync_period: assert property ($rose(sync_clk_q) |=> sync_clk_q ##1 !sync_clk_q)
      else $error("sync clock high phase wrong");
   // ==========================================================
   // covers
   c_serial: cover property (dual_serial_data_port_q);
   c_internal: cover property (io_update_out_q);
   c_profile: cover property (amp_from_profile_q);
endmodule
bind ducr2_ctrl_reg ducr2_ctrl_reg_sva u_sva (.*);

// *** verification/ducr2_host_model.sv ***
/* host side of the update pin: a two-cycle pulse on request.
   assumes the bench asks no closer than every three cycles. */
`timescale 1ns/1ns
module ducr2_host_model (
   // clock and request
   input  wire logic clk,
   input  wire logic go,
   // device side of the pin
   input  wire logic io_update_out_q,
   input  wire logic io_update_oe_q,
   output logic      io_update_in
);
   logic [1:0] cnt_q = 2'h0;
   always_ff @(posedge clk) begin
      if (go) begin
         cnt_q <= 2'h2;
      end else if (cnt_q != 2'h0) begin
         cnt_q <= cnt_q - 2'h1;
      end
   end
   // host stays off the pin while the device drives it
   assign io_update_in = io_update_oe_q ? io_update_out_q : (cnt_q != 2'h0);
endmodule

// *** verification/test_ducr2_ctrl_reg.sv ***
/* self-checking bench for the second control register block.
   assumes the host model on the update pin and the bound checker. */
`timescale 1ns/1ns
module test_ducr2_ctrl_reg;
   logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, output_shift_keying = 1'b0, go = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000, stored = 32'h1234_5678, eff = 32'h9ABC_DEF0;
   logic [1:0] op_mode = 2'b00;
   logic [31:0] rdata;
   logic rvalid, hit, uin, uout, uoe, uev, sclk, dual, lsb, early, afp, abyp;
   logic [17:0] pm, sm, gm;
   int err_count = 0, compares = 0, n;
   always #5 clk = ~clk;
   ducr2_ctrl_reg DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
      .reg_hit_q(hit), .tuning_stored(stored), .tuning_effective(eff), .op_mode(op_mode),
      .output_shift_keying_en(output_shift_keying), .update_period(16'h0003), .io_update_in(uin),
      .io_update_out_q(uout), .io_update_oe_q(uoe), .update_event_q(uev), .sync_clk_q(sclk),
      .dual_serial_data_port_q(dual), .parallel_pin_mask_q(pm), .serial_pin_mask_q(sm),
      .gpio_pin_mask_q(gm), .serial_lsb_first_q(lsb), .serial_early_fsync_q(early),
      .amp_from_profile_q(afp), .amp_bypass_q(abyp));
   ducr2_host_model u_host (.clk(clk), .go(go), .io_update_out_q(uout), .io_update_oe_q(uoe),
      .io_update_in(uin));
   // ==========================================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] d);
      @(posedge clk); reg_wr <= 1'b1; reg_addr <= ducr2_pkg::CR2_ADDR; reg_wdata <= d;
      @(posedge clk); reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic h);
      @(posedge clk); reg_rd <= 1'b1; reg_addr <= a;
      @(posedge clk); reg_rd <= 1'b0;
      #1 chk(rdata, e, "read data");
      chk({31'h0, hit}, {31'h0, h}, "address hit");
      chk({31'h0, rvalid}, 32'h1, "read valid");
   endtask
   task automatic upd;
      @(posedge clk); go <= 1'b1;
      @(posedge clk); go <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   // cycles from one internal update pulse to the next
   task automatic gap(output int g);
      int k;
      k = 0;
      while (uout !== 1'b1 && k < 200) begin @(posedge clk); #1 k++; end
      g = 0;
      do begin @(posedge clk); #1 g++; end while (uout !== 1'b1 && g < 200);
      chk({31'h0, uev}, 32'h1, "event with pulse");
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd(ducr2_pkg::CR2_ADDR, 32'h0040_0000, 1'b1);
      chk({14'h0, pm}, 32'h0003_FFFF, "parallel mask");
      n = 0;
      repeat (4) begin @(posedge clk); #1 n += sclk; end
      chk(n, 2, "sync clock duty");
      $display("test reset done");
   endtask
   task automatic t_serial;
      wr(32'hFE7E_0000);
      rd(ducr2_pkg::CR2_ADDR, 32'hE040_0000, 1'b1);
      chk({31'h0, dual}, 32'h0, "serial before update");
      upd;
      chk({29'h0, dual, lsb, early}, 32'h7, "serial flags");
      chk({14'h0, gm}, 32'h0003_FFCF, "gpio mask");
      chk({14'h0, sm}, 32'h0000_0030, "serial mask");
      @(posedge clk);
      op_mode <= 2'b01;
      repeat (2) @(posedge clk);
      #1 chk({31'h0, dual}, 32'h0, "serial outside quadrature");
      $display("test serial done");
   endtask
   task automatic t_amp;
      wr(32'h0140_0000);
      upd;
      chk({30'h0, afp, abyp}, 32'h2, "profile amplitude");
      @(posedge clk);
      output_shift_keying <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk({30'h0, afp, abyp}, 32'h0, "keying blocks source");
      @(posedge clk);
      output_shift_keying <= 1'b0;
      wr(32'h0040_0000);
      upd;
      chk({30'h0, afp, abyp}, 32'h1, "unity bypass");
      $display("test amplitude done");
   endtask
   task automatic t_tuning;
      rd(ducr2_pkg::TUNING_ADDR, 32'h1234_5678, 1'b1);
      wr(32'h0041_0000);
      upd;
      rd(ducr2_pkg::TUNING_ADDR, 32'h9ABC_DEF0, 1'b1);
      rd(8'h05, 32'h0000_0000, 1'b0);
      $display("test tuning done");
   endtask
   task automatic t_internal;
      wr(32'h00C0_4000);
      @(posedge clk);
      #1 chk({31'h0, uoe}, 32'h1, "pin driven at once");
      gap(n);
      gap(n);
      chk(n, 8, "rate two gap");
      wr(32'h00C0_8000);
      gap(n);
      gap(n);
      gap(n);
      chk(n, 16, "rate four gap");
      wr(32'h0080_8000);
      gap(n);
      gap(n);
      repeat (8) begin @(posedge clk); #1 chk({31'h0, sclk}, 32'h0, "sync held low"); end
      wr(32'h0040_0000);
      @(posedge clk);
      #1 chk({31'h0, uoe}, 32'h0, "pin back to input");
      $display("test internal update done");
   endtask
   task automatic end_of_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000 err_count++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      end_of_test;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      t_reset;
      t_serial;
      t_amp;
      t_tuning;
      t_internal;
      end_of_test;
   end
endmodule
